// ---- adc_ctrl_consts.vh ----
/*
 * Constants for the converter control and result register block.
 * Assumes inclusion by bare name from the design file in the same folder.
 */
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH

// Register byte addresses on the AXI4-Lite bus
`define OFS_CONTROL_0 4'h0
`define OFS_CONTROL_1 4'h4
`define OFS_RESULT_HIGH 4'h8
`define OFS_RESULT_LOW 4'hc

// Control register 0 fields
`define CLK_SEL_HI 7
`define CLK_SEL_LO 6
`define CHAN_SEL_HI 5
`define CHAN_SEL_LO 2
`define GO_BIT 1
`define ENABLE_BIT 0

// Control register 1 fields
`define FORMAT_BIT 7
`define NEG_REF_BIT 5
`define POS_REF_BIT 4
`define CONTROL_1_MASK 8'hb0

// Clock select codes
`define CLK_DIV2 2'h0
`define CLK_DIV8 2'h1
`define CLK_DIV32 2'h2
`define CLK_RC 2'h3

// Divider half-period counts for the three system-clock options
`define HALF_DIV2 5'h00
`define HALF_DIV8 5'h03
`define HALF_DIV32 5'h0f

// Channel codes for the two internal references
`define CHAN_CMP_REF 4'he
`define CHAN_FIXED_REF 4'hf

// Conversion length in conversion-clock periods, and abort recovery
`define CONV_PERIODS 4'hb
`define ABORT_PERIODS 2'h2

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define RESET_BYTE 8'h00

`endif

// ---- adc_control_result_regs.v ----
/*
 * Control and result registers of a 10-bit successive-approximation converter,
 * with conversion-clock generation and sequencing, behind an AXI4-Lite slave.
 * Assumes the analog core returns its 10-bit value on conversion_result_bits and
 * that the RC oscillator tick is a one-cycle pulse synchronous to clk_sys,
 * one per half period of the RC conversion clock.
 * Assumes the special-event trigger is a one-cycle pulse synchronous to clk_sys.
 * Register map: control 0 at 0x0, control 1 at 0x4, result high at 0x8, result low at 0xc.
 * Only byte lane 0 carries register data; a write with wstrb[0] low changes nothing.
 * Unmapped addresses answer SLVERR, and reads of them return zero.
 * One write and one read may be in flight at a time.
 */
//
// Overview of operation
// (R1) Clock select 00, 01, 10 gives system clock divided by 2, 8, 32.
// (R2) Clock select 11 uses the dedicated RC oscillator ticks, at most 500 kHz.
// (R3) Channel codes 0000 to 1101 route analog inputs 0 to 13.
// (R4) Code 1110 selects comparator reference; 1111 selects fixed 0.6 V reference.
// (R5) Writing one to the status bit starts conversion; reads one while running.
// (R6) Hardware clears the status bit when the conversion finishes.
// (R7) Status bit reads zero when no conversion runs.
// (R8) Enable bit powers the converter; cleared means off with no current.
// (R9) Format bit one gives right-justified results, zero left-justified.
// (R10) Negative reference bit picks external pin when one, ground when zero.
// (R11) Positive reference bit picks external pin when one, supply when zero.
// (R12) Control 1 bit 6 and bits 3-0 ignore writes and read zero.
// (R13) Left format: result high holds result bits 9 down to 2.
// (R14) Left format: result low holds bits 1-0 in bits 7-6.
// (R15) Right format: result high holds bits 9-8 in bits 1-0.
// (R16) Right format: result low holds result bits 7 down to 0.
// (R17) Completion clears status, sets interrupt flag, loads both result registers.
// (R18) Early clear keeps old result; next acquisition waits two clock periods.
// (R19) Interrupt flag set at every completion; only software clears it.
// (R20) Special-event trigger sets the status bit and starts a conversion.
// (R21) Control bits reset to zero; results change only at completion. The code also loads either result byte from a bus write to its address.
// (R22) Both result registers update in the same clock cycle.
//
module adc_control_result_regs #(
  parameter RESULT_WIDTH = 10,
  parameter CHANNEL_COUNT = 14
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rc_osc_tick,
  input wire special_event_trigger,
  input wire interrupt_flag_clear,
  input wire [RESULT_WIDTH-1:0] conversion_result_bits,
  output reg converter_interrupt_flag,
  output reg converter_powered,
  output reg [CHANNEL_COUNT-1:0] analog_input_route,
  output reg comparator_reference_route,
  output reg fixed_reference_route,
  output reg negative_ref_from_pin,
  output reg positive_ref_from_pin,
  output reg sample_hold,
  output reg conversion_clock_period
);
`include "adc_ctrl_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [7:0] converter_control_0;
reg [7:0] converter_control_1;
reg [7:0] conversion_result_high;
reg [7:0] conversion_result_low;

wire [1:0] conversion_clock_select = converter_control_0[`CLK_SEL_HI:`CLK_SEL_LO];
wire [3:0] input_channel_select = converter_control_0[`CHAN_SEL_HI:`CHAN_SEL_LO];
wire converter_power_enable = converter_control_0[`ENABLE_BIT];
wire conversion_go = converter_control_0[`GO_BIT];
wire result_format_select = converter_control_1[`FORMAT_BIT];

////////////////////////////////////////////////////////////////////////////////
// Conversion clock

reg [4:0] div_count;
reg [4:0] div_half;
wire tad_tick;

// Half-period length of the system-clock divider
always @* begin
  case (conversion_clock_select) // see (R1)
    `CLK_DIV2: div_half = `HALF_DIV2;
    `CLK_DIV8: div_half = `HALF_DIV8;
    default: div_half = `HALF_DIV32;
  endcase
end

// Wraps also when a switch to a faster setting leaves the count above its limit
wire div_wrap = div_count >= div_half;

// One tick per full conversion-clock period; each RC tick is only half a period
assign tad_tick = (conversion_clock_select == `CLK_RC) ? (rc_osc_tick && conversion_clock_period) : // see (R2)
                  (conversion_clock_period && div_wrap);

always @(posedge clk_sys) begin
  if (sys_rst || !converter_power_enable) begin // see (R8)
    div_count <= 5'h00;
    conversion_clock_period <= 1'b0;
  end else if (conversion_clock_select == `CLK_RC) begin
    div_count <= 5'h00;
    if (rc_osc_tick) begin
      conversion_clock_period <= ~conversion_clock_period;
    end
  end else if (div_wrap) begin
    div_count <= 5'h00;
    conversion_clock_period <= ~conversion_clock_period;
  end else begin
    div_count <= div_count + 5'h01;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer

// Idle waits for a start, convert counts conversion-clock periods, and recover
// holds off any restart for two periods after an abort
localparam ST_IDLE = 2'h0;
localparam ST_CONVERT = 2'h1;
localparam ST_RECOVER = 2'h2;

reg [1:0] state;
reg [3:0] period_count;
reg conversion_done;

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave

reg aw_held;
reg w_held;
reg [3:0] aw_addr;
reg [7:0] w_byte;
reg w_lane;

// Address and data are taken in either order; each is parked until its partner comes,
// and nothing new is taken while a response waits
assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready = !w_held && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

wire aw_fire = s_axi_awvalid && s_axi_awready;
wire w_fire = s_axi_wvalid && s_axi_wready;
wire have_aw = aw_held || aw_fire;
wire have_w = w_held || w_fire;
wire [3:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
wire [7:0] wr_byte = w_held ? w_byte : s_axi_wdata[7:0];
wire wr_lane = w_held ? w_lane : s_axi_wstrb[0];
wire do_write = have_aw && have_w;
wire wr_known = (wr_addr == `OFS_CONTROL_0) || (wr_addr == `OFS_CONTROL_1) ||
                (wr_addr == `OFS_RESULT_HIGH) || (wr_addr == `OFS_RESULT_LOW);
wire wr_ctl0 = do_write && wr_lane && wr_addr == `OFS_CONTROL_0;
wire wr_ctl1 = do_write && wr_lane && wr_addr == `OFS_CONTROL_1;
wire wr_res_hi = do_write && wr_lane && wr_addr == `OFS_RESULT_HIGH;
wire wr_res_lo = do_write && wr_lane && wr_addr == `OFS_RESULT_LOW;

always @(posedge clk_sys) begin
  if (sys_rst) begin
    aw_held <= 1'b0;
    w_held <= 1'b0;
    aw_addr <= 4'h0;
    w_byte <= `RESET_BYTE;
    w_lane <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `RESP_OKAY;
  end else begin
    if (do_write) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
    end else begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
end

always @(posedge clk_sys) begin
  if (sys_rst) begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h00000000;
    s_axi_rresp <= `RESP_OKAY;
  end else if (s_axi_arvalid && s_axi_arready) begin
    s_axi_rvalid <= 1'b1;
    s_axi_rresp <= `RESP_OKAY;
    case (s_axi_araddr)
      `OFS_CONTROL_0: s_axi_rdata <= {24'h000000, converter_control_0}; // see (R5) (R7)
      `OFS_CONTROL_1: s_axi_rdata <= {24'h000000, converter_control_1}; // see (R12)
      `OFS_RESULT_HIGH: s_axi_rdata <= {24'h000000, conversion_result_high};
      `OFS_RESULT_LOW: s_axi_rdata <= {24'h000000, conversion_result_low};
      default: begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RESP_SLVERR;
      end
    endcase
  end else if (s_axi_rvalid && s_axi_rready) begin
    s_axi_rvalid <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Control registers and sequencing

// Software or trigger setting the status bit while idle, with the enable bit already set, starts a conversion
wire sw_go = wr_ctl0 && wr_byte[`GO_BIT];
wire start_req = (sw_go || special_event_trigger) && converter_power_enable; // see (R20)
wire sw_abort = wr_ctl0 && !wr_byte[`GO_BIT] && state == ST_CONVERT;

always @(posedge clk_sys) begin
  if (sys_rst) begin
    converter_control_0 <= `RESET_BYTE; // see (R21)
    converter_control_1 <= `RESET_BYTE;
    state <= ST_IDLE;
    period_count <= 4'h0;
    conversion_done <= 1'b0;
  end else begin
    conversion_done <= 1'b0;
    if (wr_ctl0) begin
      converter_control_0 <= wr_byte;
    end
    if (wr_ctl1) begin
      converter_control_1 <= wr_byte & `CONTROL_1_MASK; // see (R12)
    end
    // Outside idle a write to the status bit can only end a run, never start one
    case (state)
      ST_IDLE: begin
        period_count <= 4'h0;
        if (start_req) begin
          converter_control_0[`GO_BIT] <= 1'b1; // see (R5) (R20)
          state <= ST_CONVERT;
        end else begin
          // Go written while the converter is off, or any stale go, is dropped
          converter_control_0[`GO_BIT] <= 1'b0; // see (R7)
        end
      end
      ST_CONVERT: begin
        if (sw_abort || !converter_power_enable) begin // see (R18)
          converter_control_0[`GO_BIT] <= 1'b0;
          period_count <= 4'h0;
          state <= ST_RECOVER;
        end else if (tad_tick) begin
          if (period_count == `CONV_PERIODS - 4'h1) begin
            converter_control_0[`GO_BIT] <= 1'b0; // see (R6) (R17)
            conversion_done <= 1'b1;
            state <= ST_IDLE;
          end else begin
            period_count <= period_count + 4'h1;
          end
        end
      end
      ST_RECOVER: begin
        // Starts written during recovery are dropped
        if (wr_ctl0) begin
          converter_control_0[`GO_BIT] <= 1'b0;
        end
        if (!converter_power_enable) begin
          state <= ST_IDLE;
        end else if (tad_tick) begin
          if (period_count[1:0] == `ABORT_PERIODS - 2'h1) begin // see (R18)
            state <= ST_IDLE;
          end else begin
            period_count <= period_count + 4'h1;
          end
        end
      end
      default: state <= ST_IDLE;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Results and interrupt flag

// Both bytes load together on completion, a bus write loads either one alone; reset leaves them as they were
// They load one cycle after the status bit clears, too early for any poll to see
always @(posedge clk_sys) begin
  if (conversion_done) begin // see (R17) (R22)
    if (result_format_select) begin // see (R9)
      conversion_result_high <= {6'h00, conversion_result_bits[9:8]}; // see (R15)
      conversion_result_low <= conversion_result_bits[7:0]; // see (R16)
    end else begin
      conversion_result_high <= conversion_result_bits[9:2]; // see (R13)
      conversion_result_low <= {conversion_result_bits[1:0], 6'h00}; // see (R14)
    end
  end else begin
    if (wr_res_hi) begin
      conversion_result_high <= wr_byte;
    end
    if (wr_res_lo) begin
      conversion_result_low <= wr_byte;
    end
  end
end

always @(posedge clk_sys) begin
  if (sys_rst) begin
    converter_interrupt_flag <= 1'b0;
  end else if (conversion_done) begin
    converter_interrupt_flag <= 1'b1; // see (R19)
  end else if (interrupt_flag_clear) begin
    converter_interrupt_flag <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Analog control outputs

// One route enable per analog input
genvar ch;
generate
  for (ch = 0; ch < CHANNEL_COUNT; ch = ch + 1) begin : route_gen
    always @(posedge clk_sys) begin
      if (sys_rst) begin
        analog_input_route[ch] <= 1'b0;
      end else begin
        analog_input_route[ch] <= converter_power_enable && input_channel_select == ch; // see (R3)
      end
    end
  end
endgenerate

// A run halts the moment the enable bit drops, before the sequencer leaves convert
wire running = (state == ST_CONVERT) && conversion_go && converter_power_enable;
wire route_cmp = converter_power_enable && input_channel_select == `CHAN_CMP_REF;
wire route_fixed = converter_power_enable && input_channel_select == `CHAN_FIXED_REF;

always @(posedge clk_sys) begin
  if (sys_rst) begin
    converter_powered <= 1'b0;
    comparator_reference_route <= 1'b0;
    fixed_reference_route <= 1'b0;
    negative_ref_from_pin <= 1'b0;
    positive_ref_from_pin <= 1'b0;
    sample_hold <= 1'b0;
  end else begin
    converter_powered <= converter_power_enable; // see (R8)
    comparator_reference_route <= route_cmp; // see (R4)
    fixed_reference_route <= route_fixed; // see (R4)
    negative_ref_from_pin <= converter_control_1[`NEG_REF_BIT]; // see (R10)
    positive_ref_from_pin <= converter_control_1[`POS_REF_BIT]; // see (R11)
    sample_hold <= running; // see (R5) (R8)
  end
end

endmodule // adc_control_result_regs

// ---- adc_ctrl_checker_assertions.sv ----
/* Checker for the converter control and result register block.
   Assumes binding to the ports of adc_control_result_regs. */
module adc_ctrl_checker #(parameter CHANNEL_COUNT = 14) (
  input wire clk_sys,
  input wire sys_rst,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire interrupt_flag_clear,
  input wire converter_interrupt_flag,
  input wire converter_powered,
  input wire [CHANNEL_COUNT-1:0] analog_input_route,
  input wire comparator_reference_route,
  input wire fixed_reference_route,
  input wire sample_hold
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_flag_sticky: assert property (converter_interrupt_flag && !interrupt_flag_clear
    |=> converter_interrupt_flag)
    else $error("interrupt flag dropped without clear");
  a_flag_at_done: assert property ($rose(converter_interrupt_flag)
    |-> !sample_hold && ($past(sample_hold) || $past(sample_hold, 2)))
    else $error("interrupt flag rose outside completion");
  a_route_single: assert property ($onehot0({fixed_reference_route, comparator_reference_route,
    analog_input_route}))
    else $error("more than one input routed");
  a_off_quiet: assert property (!converter_powered |-> analog_input_route == '0
    && !comparator_reference_route && !fixed_reference_route && !sample_hold)
    else $error("converter active while disabled");
  a_run_powered: assert property ($rose(sample_hold) |-> converter_powered)
    else $error("conversion started while disabled");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
endmodule // adc_ctrl_checker

bind adc_control_result_regs adc_ctrl_checker #(.CHANNEL_COUNT(CHANNEL_COUNT)) u_chk (.clk_sys, .sys_rst,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .interrupt_flag_clear, .converter_interrupt_flag, .converter_powered, .analog_input_route,
  .comparator_reference_route, .fixed_reference_route, .sample_hold);

// ---- tb_top.sv ----
/* Self-checking bench for adc_control_result_regs.
   Assumes the constants header beside it; registers reached over AXI4-Lite. */
`include "adc_ctrl_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = '0, sys_rst = 1'h1, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, rc_osc_tick = '0, special_event_trigger = '0, interrupt_flag_clear = '0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = '0, rd_data, old;
  logic [9:0] conversion_result_bits = '0;
  logic [1:0] rd_resp, wr_resp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, converter_interrupt_flag;
  wire converter_powered, comparator_reference_route, fixed_reference_route, negative_ref_from_pin;
  wire positive_ref_from_pin, sample_hold, conversion_clock_period;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [13:0] analog_input_route;
  int error_cnt = 0, samples_checked = 0, cycles = 0, tk = 0;

  adc_control_result_regs dut (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rc_osc_tick,
    .special_event_trigger, .interrupt_flag_clear, .conversion_result_bits, .converter_interrupt_flag,
    .converter_powered, .analog_input_route, .comparator_reference_route, .fixed_reference_route,
    .negative_ref_from_pin, .positive_ref_from_pin, .sample_hold, .conversion_clock_period);

  always #20 clk_sys = ~clk_sys;

  // RC oscillator ticks every 25 cycles: 500 kHz conversion clock
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    tk <= (tk == 24) ? 0 : tk + 1;
    rc_osc_tick <= (tk == 24);
    if (cycles == 20000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish;
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (!s_axi_bvalid) s_axi_bready <= 1'h1;
    end while (!s_axi_bvalid);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (!s_axi_rvalid) s_axi_rready <= 1'h1;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic wait_done(output int n);
    n = 0;
    while (sample_hold === 1'h1 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(`OFS_CONTROL_0);
    chk(rd_data, 32'h0);
    rd(`OFS_CONTROL_1);
    chk(rd_data, 32'h0);
    rd(4'h2);
    chk({rd_resp, rd_data}, {`RESP_SLVERR, 32'h0});
    wr(4'h2, 8'h5a);
    chk(wr_resp, `RESP_SLVERR);
    wr(`OFS_CONTROL_1, 8'hff);
    chk(wr_resp, `RESP_OKAY);
    rd(`OFS_CONTROL_1);
    chk(rd_data, 32'hb0);
    chk({negative_ref_from_pin, positive_ref_from_pin}, 2'h3);
    wr(`OFS_CONTROL_1, 8'h4f);
    rd(`OFS_CONTROL_1);
    chk({negative_ref_from_pin, positive_ref_from_pin, rd_data}, 34'h0);
  endtask

  task automatic t_routes;
    for (int c = 0; c < 16; c++) begin
      wr(`OFS_CONTROL_0, {2'h0, c[3:0], 2'h1});
      rd(`OFS_CONTROL_0);
      chk(rd_data, {2'h0, c[3:0], 2'h1});
      chk({fixed_reference_route, comparator_reference_route, analog_input_route}, 16'h1 << c);
    end
    wr(`OFS_CONTROL_0, 8'h0c);
    rd(`OFS_CONTROL_0);
    chk({converter_powered, conversion_clock_period, fixed_reference_route, analog_input_route}, 17'h0);
  endtask

  task automatic t_conv(input logic [1:0] cs, input logic fm, input logic [9:0] v);
    int n, p;
    p = (cs == `CLK_DIV2) ? 2 : (cs == `CLK_DIV8) ? 8 : (cs == `CLK_DIV32) ? 32 : 50;
    wr(`OFS_CONTROL_1, {fm, 7'h0});
    wr(`OFS_CONTROL_0, {cs, 6'h15});
    conversion_result_bits <= v;
    wr(`OFS_CONTROL_0, {cs, 6'h17});
    rd(`OFS_CONTROL_0);
    chk(rd_data, {cs, 6'h17});
    wait_done(n);
    chk(n >= 9 * p - 6 && n <= 13 * p + 8, 1'h1);
    rd(`OFS_CONTROL_0);
    chk({rd_data[1], converter_interrupt_flag}, 2'h1);
    rd(`OFS_RESULT_HIGH);
    chk(rd_data & (fm ? 8'h03 : 8'hff), fm ? v[9:8] : v[9:2]);
    rd(`OFS_RESULT_LOW);
    chk(rd_data & (fm ? 8'hff : 8'hc0), fm ? v[7:0] : {v[1:0], 6'h0});
    interrupt_flag_clear <= 1'h1;
    @(posedge clk_sys);
    interrupt_flag_clear <= 1'h0;
    repeat (2) @(posedge clk_sys);
    chk(converter_interrupt_flag, 1'h0);
  endtask

  // Abort keeps old result, ignores a restart during recovery and takes one after it
  task automatic t_abort;
    rd(`OFS_RESULT_LOW);
    old = rd_data;
    conversion_result_bits <= 10'h155;
    wr(`OFS_CONTROL_0, 8'h97);
    repeat (40) @(posedge clk_sys);
    wr(`OFS_CONTROL_0, 8'h95);
    wr(`OFS_CONTROL_0, 8'h97);
    rd(`OFS_CONTROL_0);
    chk(rd_data, 32'h95);
    rd(`OFS_RESULT_LOW);
    chk({converter_interrupt_flag, rd_data}, {1'h0, old});
    repeat (80) @(posedge clk_sys);
    wr(`OFS_CONTROL_0, 8'h97);
    rd(`OFS_CONTROL_0);
    chk(rd_data, 32'h97);
    wr(`OFS_CONTROL_0, 8'h95);
  endtask

  // Reset while enabled and idle clears the control bytes and leaves result high alone
  task automatic t_reset;
    rd(`OFS_RESULT_HIGH);
    old = rd_data;
    wr(`OFS_CONTROL_1, 8'hb0);
    wr(`OFS_CONTROL_0, 8'hfd);
    sys_rst <= 1'h1;
    @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(`OFS_CONTROL_0);
    chk(rd_data, 32'h0);
    rd(`OFS_CONTROL_1);
    chk(rd_data, 32'h0);
    rd(`OFS_RESULT_HIGH);
    chk(rd_data, old);
    chk({converter_powered, negative_ref_from_pin, positive_ref_from_pin}, 3'h0);
  endtask

  task automatic t_trigger;
    int n;
    wr(`OFS_CONTROL_0, 8'h15);
    repeat (80) @(posedge clk_sys);
    special_event_trigger <= 1'h1;
    @(posedge clk_sys);
    special_event_trigger <= 1'h0;
    rd(`OFS_CONTROL_0);
    chk(rd_data, 32'h17);
    wait_done(n);
    @(posedge clk_sys);
    chk(converter_interrupt_flag, 1'h1);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'h0;
    @(posedge clk_sys);
    t_regs;
    t_routes;
    for (int c = 0; c < 4; c++) t_conv(c[1:0], c[0], 10'h2a7 ^ {8'h0, c[1:0]});
    t_abort;
    t_trigger;
    t_reset;
    tally_and_finish;
  end
endmodule // tb_top
